// [hdl/hpsr_ctrl.sv]
`timescale 1ns/1ps
// Summary of operation
// - diff bit is one when plus exceeds minus
// - no repeated traffic to suspended ports
// - block foreign resume to suspended ports
// - port resume: reflect K, status, interrupt
// - disconnect clears port suspend bit
// - remote wakeup bit gates connect resume
// - remote wakeup resume always propagated
// - suspend and resume registers clear on resets
// - resume bits read-only, upper bits zero
// - clearing suspend clears resume and K
// - hub-suspend resume: K up, wake, interrupt
// - wake holds firmware at least 1 ms
// - upstream force code drives lines
// - upstream control clears on reset
// - activity flag sticky, write zero clears
// - status bits show upstream line levels
// - endpoint bits steer serial engine
// - EOP on downstream at EOF1
module hpsr_ctrl #(
  parameter int PORTS = 4,
  parameter int HOLDOFF_CYCLES = hpsr_pkg::HOLDOFF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic bus_reset_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [PORTS-1:0] ds_dp_in,
  input wire logic [PORTS-1:0] ds_dm_in,
  input wire logic [PORTS-1:0] ds_connected_in,
  input wire logic [PORTS-1:0] ds_repeat_in,
  output logic [PORTS-1:0] ds_repeat_out,
  output logic [PORTS-1:0] ds_resume_k_out,
  input wire logic eof1_in,
  output logic ds_eop_out,
  input wire logic hub_suspended_in,
  input wire logic us_resume_in,
  output logic us_resume_k_out,
  output logic wake_out,
  output logic fw_hold_out,
  output logic hub_irq_out,
  input wire logic se_activity_in,
  input wire logic se_dp_in,
  input wire logic se_dm_in,
  input wire logic se_oe_in,
  input wire logic us_dp_in,
  input wire logic us_dm_in,
  output logic us_dp_out,
  output logic us_dm_out,
  output logic us_dp_oe_out,
  output logic us_dm_oe_out,
  output logic ep_size_out,
  output logic ep_mode_out
);
  logic [7:0] usc_q;
  logic [7:0] usc_d;
  logic [PORTS-1:0] susp_q;
  logic [PORTS-1:0] susp_d;
  logic rwake_q;
  logic rwake_d;
  logic [PORTS-1:0] res_q;
  logic [PORTS-1:0] res_d;
  logic [PORTS-1:0] conn_q;
  logic [PORTS-1:0] diff_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic hold_q;
  logic [31:0] hold_cnt_q;
  logic wake_q;
  logic eop_q;
  logic [PORTS-1:0] k_state;
  logic [PORTS-1:0] diff_state;
  logic [PORTS-1:0] res_new;
  logic [PORTS-1:0] conn_evt;
  logic [PORTS-1:0] disc;
  logic any_res;
  logic conn_wake;
  logic wake_evt;
  logic req;
  logic wr_en;
  logic rd_en;
  logic hit_usc;
  logic hit_susp;
  logic hit_res;
  logic hit_diff;
  logic [7:0] rd_mux;
  logic [7:0] wd;
  logic [2:0] fc;

  // bus decode, one wait cycle then acknowledge
  assign req = avs_read_in | avs_write_in;
  assign wr_en = avs_write_in & ack_q;
  assign rd_en = avs_read_in & ~ack_q;
  assign avs_waitrequest_out = req & ~ack_q;
  assign avs_readdata_out = rdata_q;
  assign wd = avs_writedata_in[7:0];
  assign hit_usc = avs_address_in == hpsr_pkg::ADDR_USC;
  assign hit_susp = avs_address_in == hpsr_pkg::ADDR_SUSP;
  assign hit_res = avs_address_in == hpsr_pkg::ADDR_RES;
  assign hit_diff = avs_address_in == hpsr_pkg::ADDR_DIFF;

  // per-port line state
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++)
    begin : g_port
      // K is minus high, plus low
      assign k_state[gi] = ds_dm_in[gi] & ~ds_dp_in[gi];
      assign diff_state[gi] = ds_dp_in[gi] ^ ds_dm_in[gi];
      // resume seen on a suspended port
      assign res_new[gi] = susp_q[gi] & k_state[gi];
      assign disc[gi] = conn_q[gi] & ~ds_connected_in[gi];
      assign conn_evt[gi] = conn_q[gi] ^ ds_connected_in[gi];
    end
  endgenerate

  // gate repeater; own resume still reflected
  assign ds_repeat_out = ds_repeat_in & ~susp_q;
  // hardware K only while suspend bit holds
  assign ds_resume_k_out = res_q & susp_q;
  assign any_res = |res_new;
  // connect change resume gated by wakeup bit
  assign conn_wake = rwake_q & (|conn_evt);
  assign wake_evt = hub_suspended_in & (any_res | conn_wake | us_resume_in);
  assign us_resume_k_out = wake_q;
  assign wake_out = wake_q;
  assign fw_hold_out = hold_q;
  assign hub_irq_out = irq_q;
  assign ds_eop_out = eop_q;
  assign ep_size_out = usc_q[hpsr_pkg::BIT_EPSIZE];
  assign ep_mode_out = usc_q[hpsr_pkg::BIT_EPMODE];

  // register next values
  always_comb
  begin
    usc_d = usc_q;
    susp_d = susp_q;
    rwake_d = rwake_q;
    if (wr_en && hit_usc)
    begin
      usc_d[2:0] = wd[2:0];
      usc_d[7:6] = wd[7:6];
      usc_d[hpsr_pkg::BIT_ACT] = usc_q[hpsr_pkg::BIT_ACT] & wd[hpsr_pkg::BIT_ACT];
    end
    if (se_activity_in)
      usc_d[hpsr_pkg::BIT_ACT] = 1'b1;
    usc_d[hpsr_pkg::BIT_DM] = us_dm_in;
    usc_d[hpsr_pkg::BIT_DP] = us_dp_in;
    if (wr_en && hit_susp)
    begin
      susp_d = wd[PORTS-1:0];
      rwake_d = wd[hpsr_pkg::BIT_RWAKE];
    end
    susp_d = susp_d & ~disc;
    res_d = (res_q | res_new) & susp_d;
  end

  // read data mux
  always_comb
  begin
    rd_mux = hpsr_pkg::RESET_VAL;
    if (hit_usc)
      rd_mux = usc_q;
    else if (hit_susp)
      rd_mux = {rwake_q, 3'h0, susp_q};
    else if (hit_res)
      rd_mux = {4'h0, res_q};
    else if (hit_diff)
      rd_mux = {4'h0, diff_q};
  end

  assign fc = usc_q[2:0];
  always_comb
  begin
    us_dp_out = se_dp_in;
    us_dm_out = se_dm_in;
    us_dp_oe_out = se_oe_in;
    us_dm_oe_out = se_oe_in;
    case (fc)
      hpsr_pkg::FC_NONE:
      begin
        us_dp_out = se_dp_in;
      end
      hpsr_pkg::FC_J:
      begin
        us_dp_out = 1'b1;
        us_dm_out = 1'b0;
        us_dp_oe_out = 1'b1;
        us_dm_oe_out = 1'b1;
      end
      hpsr_pkg::FC_K:
      begin
        us_dp_out = 1'b0;
        us_dm_out = 1'b1;
        us_dp_oe_out = 1'b1;
        us_dm_oe_out = 1'b1;
      end
      hpsr_pkg::FC_SE0, hpsr_pkg::FC_LOW:
      begin
        us_dp_out = 1'b0;
        us_dm_out = 1'b0;
        us_dp_oe_out = 1'b1;
        us_dm_oe_out = 1'b1;
      end
      hpsr_pkg::FC_ZP:
      begin
        us_dp_out = 1'b0;
        us_dm_out = 1'b0;
        us_dp_oe_out = 1'b0;
        us_dm_oe_out = 1'b1;
      end
      hpsr_pkg::FC_ZM:
      begin
        us_dp_out = 1'b0;
        us_dm_out = 1'b0;
        us_dp_oe_out = 1'b1;
        us_dm_oe_out = 1'b0;
      end
      hpsr_pkg::FC_ZZ:
      begin
        us_dp_out = 1'b0;
        us_dm_out = 1'b0;
        us_dp_oe_out = 1'b0;
        us_dm_oe_out = 1'b0;
      end
      default:
      begin
        us_dp_out = se_dp_in;
      end
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (rd_en)
        rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      usc_q <= hpsr_pkg::RESET_VAL;
    else
      usc_q <= usc_d;
  end

  // suspend and resume clear on both resets
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      susp_q <= '0;
      rwake_q <= 1'b0;
      res_q <= '0;
    end
    else if (bus_reset_in)
    begin
      susp_q <= '0;
      rwake_q <= 1'b0;
      res_q <= '0;
    end
    else
    begin
      susp_q <= susp_d;
      rwake_q <= rwake_d;
      res_q <= res_d;
    end
  end

  // line samples, interrupt and EOF1 end-of-packet
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      conn_q <= '0;
      diff_q <= '0;
      irq_q <= 1'b0;
      eop_q <= 1'b0;
    end
    else
    begin
      conn_q <= ds_connected_in;
      diff_q <= (diff_q & ~diff_state) | (ds_dp_in & diff_state);
      irq_q <= any_res | wake_evt;
      eop_q <= eof1_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wake_q <= 1'b0;
      hold_q <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
    end
    else if (wake_evt)
    begin
      wake_q <= 1'b1;
      hold_q <= 1'b1;
      hold_cnt_q <= 32'(HOLDOFF_CYCLES);
    end
    else if (hold_q)
    begin
      wake_q <= 1'b0;
      hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
      if (hold_cnt_q <= 32'h0000_0001)
        hold_q <= 1'b0;
    end
    else
      wake_q <= 1'b0;
  end
endmodule // hpsr_ctrl

// [hdl/hpsr_pkg.sv]
package hpsr_pkg;
  // register byte addresses (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_USC = 8'h1F;
  localparam logic [7:0] IDX_SUSP = 8'h4D;
  localparam logic [7:0] IDX_RES = 8'h4E;
  localparam logic [7:0] IDX_DIFF = 8'h4F;
  localparam logic [9:0] ADDR_USC = {IDX_USC, 2'b00};
  localparam logic [9:0] ADDR_SUSP = {IDX_SUSP, 2'b00};
  localparam logic [9:0] ADDR_RES = {IDX_RES, 2'b00};
  localparam logic [9:0] ADDR_DIFF = {IDX_DIFF, 2'b00};
  // field positions
  localparam int BIT_RWAKE = 7;
  localparam int BIT_ACT = 3;
  localparam int BIT_DM = 4;
  localparam int BIT_DP = 5;
  localparam int BIT_EPMODE = 6;
  localparam int BIT_EPSIZE = 7;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // upstream force codes
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_J = 3'h1;
  localparam logic [2:0] FC_K = 3'h2;
  localparam logic [2:0] FC_SE0 = 3'h3;
  localparam logic [2:0] FC_LOW = 3'h4;
  localparam logic [2:0] FC_ZP = 3'h5;
  localparam logic [2:0] FC_ZM = 3'h6;
  localparam logic [2:0] FC_ZZ = 3'h7;
  // wake hold-off
  localparam int CLK_MHZ = 100;
  localparam int HOLDOFF_US = 1000;
  localparam int HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ;
endpackage

// [testbench/hpsr_usb_model.sv]
`timescale 1ns/1ps
module hpsr_usb_model (
  input wire logic [3:0] k_in,
  input wire logic [3:0] conn_in,
  output logic [3:0] dp_out,
  output logic [3:0] dm_out,
  input wire logic dp_drv_in,
  input wire logic dm_drv_in,
  input wire logic dp_oe_in,
  input wire logic dm_oe_in,
  output logic us_dp_out,
  output logic us_dm_out
);
  // devices: detached port pulled low, idle J, resume request K
  assign dp_out = conn_in & ~k_in;
  assign dm_out = conn_in & k_in;
  // upstream wire: pull-up on plus, host pull-down on minus
  assign us_dp_out = dp_oe_in ? dp_drv_in : 1'b1;
  assign us_dm_out = dm_oe_in ? dm_drv_in : 1'b0;
endmodule // hpsr_usb_model

// [testbench/hpsr_ctrl_assertions.sv]
`timescale 1ns/1ps
module hpsr_ctrl_assertions #(
  parameter int PORTS = 4,
  parameter int HOLDOFF_CYCLES = hpsr_pkg::HOLDOFF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic [PORTS-1:0] ds_dp_in,
  input wire logic [PORTS-1:0] ds_dm_in,
  input wire logic [PORTS-1:0] ds_repeat_in,
  input wire logic [PORTS-1:0] ds_repeat_out,
  input wire logic [PORTS-1:0] ds_resume_k_out,
  input wire logic eof1_in,
  input wire logic ds_eop_out,
  input wire logic hub_suspended_in,
  input wire logic us_resume_in,
  input wire logic us_resume_k_out,
  input wire logic wake_out,
  input wire logic fw_hold_out,
  input wire logic hub_irq_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  // length of the current firmware hold
  int hold_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
      hold_q <= 0;
    else
      hold_q <= fw_hold_out ? hold_q + 1 : 0;
  // ports showing K on their lines
  logic [PORTS-1:0] k_seen;
  assign k_seen = ds_dm_in & ~ds_dp_in;
  // one wait cycle per access
  sequence wait_one_s;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  // wake: interrupt and upstream K, then hold
  sequence wake_set_s;
    hub_irq_out && us_resume_k_out ##[0:1] fw_hold_out;
  endsequence
  bus_wait_a: assert property ($rose(avs_read_in || avs_write_in) |-> wait_one_s)
    else $error("waitrequest not one cycle");
  eop_gen_a: assert property (eof1_in |=> ds_eop_out)
    else $error("no eop after eof1");
  eop_src_a: assert property (ds_eop_out |-> $past(eof1_in))
    else $error("eop without eof1");
  repeat_gate_a: assert property ((ds_repeat_out & ~ds_repeat_in) == '0)
    else $error("traffic repeated without enable");
  k_cause_a: assert property (
    (ds_resume_k_out & ~$past(ds_resume_k_out) & ~$past(k_seen)) == '0)
    else $error("port K without port resume");
  wake_all_a: assert property (wake_out |-> wake_set_s)
    else $error("wake incomplete");
  hold_len_a: assert property ($fell(fw_hold_out) |-> hold_q >= HOLDOFF_CYCLES)
    else $error("firmware hold too short");
  us_wake_a: assert property ($rose(us_resume_in) && hub_suspended_in |-> ##[1:2] wake_out)
    else $error("resume request not propagated");
  repeat_k_a: assert property ((ds_repeat_out & ds_resume_k_out) == '0)
    else $error("traffic repeated to resuming port");
endmodule // hpsr_ctrl_assertions
bind hpsr_ctrl hpsr_ctrl_assertions #(.PORTS(PORTS), .HOLDOFF_CYCLES(HOLDOFF_CYCLES)) i_chk (.*);

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int HOLD = 8;
  localparam logic [31:0] TBL = 32'h082AABE0;
  localparam logic [9:0] USC = hpsr_pkg::ADDR_USC;
  localparam logic [9:0] SU = hpsr_pkg::ADDR_SUSP;
  localparam logic [9:0] RS = hpsr_pkg::ADDR_RES;
  logic clk_sys_in = 0, reset_n_in = 0, bus_reset_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic [9:0] avs_address_in = '0;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
  logic [3:0] ds_dp_in, ds_dm_in, ds_repeat_out, ds_resume_k_out, k = '0;
  logic [3:0] ds_connected_in = 4'hF, ds_repeat_in = 4'hF;
  logic avs_waitrequest_out, eof1_in = 0, ds_eop_out, hub_suspended_in = 0, us_resume_in = 0;
  logic us_resume_k_out, wake_out, fw_hold_out, hub_irq_out, se_activity_in = 0;
  logic se_dp_in = 0, se_dm_in = 0, se_oe_in = 0, us_dp_in, us_dm_in, us_dp_out, us_dm_out;
  logic us_dp_oe_out, us_dm_oe_out, ep_size_out, ep_mode_out;
  int failures = 0, n_checks = 0, irqs = 0, wakes = 0;
  hpsr_ctrl #(.HOLDOFF_CYCLES(HOLD)) i_dut (.*);
  hpsr_usb_model i_far (.k_in(k), .conn_in(ds_connected_in), .dp_out(ds_dp_in),
    .dm_out(ds_dm_in), .dp_drv_in(us_dp_out), .dm_drv_in(us_dm_out), .dp_oe_in(us_dp_oe_out),
    .dm_oe_in(us_dm_oe_out), .us_dp_out(us_dp_in), .us_dm_out(us_dm_in));
  always #5 clk_sys_in = ~clk_sys_in;
  // count settled event pulses mid-cycle
  always @(negedge clk_sys_in)
  begin
    irqs += (hub_irq_out === 1'b1);
    wakes += (wake_out === 1'b1);
  end
  task close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one bus access, held until waitrequest is low at an edge
  task acc(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    logic wt;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    do
    begin
      @(negedge clk_sys_in);
      wt = avs_waitrequest_out;
      @(posedge clk_sys_in);
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      failures++;
      close_out();
    end
    r = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    acc(1'b1, a, d, q);
  endtask
  task rdc(input logic [9:0] a, input logic [31:0] e);
    acc(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task t_susp();
    rdc(SU, 32'h0);
    rdc(RS, 32'h0);
    rdc(USC, 32'h20);
    rdc(10'h000, 32'h0);
    wr(SU, 8'hFF);
    rdc(SU, 32'h8F);
    chk("repeat", ds_repeat_out, 32'h0);
    wr(RS, 8'hFF);
    rdc(RS, 32'h0);
    wr(SU, 8'h01);
    chk("repeat", ds_repeat_out, 32'hE);
    $display("done suspend");
  endtask
  task t_port();
    int i;
    i = irqs;
    k <= 4'h3;
    tick(2);
    rdc(hpsr_pkg::ADDR_DIFF, 32'hC);
    k <= 4'h0;
    tick(2);
    chk("irq", irqs > i, 32'h1);
    rdc(RS, 32'h1);
    chk("kout", ds_resume_k_out, 32'h1);
    // firmware disables the resuming port
    ds_repeat_in <= 4'hE;
    wr(SU, 8'h06);
    rdc(RS, 32'h0);
    chk("kout", ds_resume_k_out, 32'h0);
    chk("repeat", ds_repeat_out, 32'h8);
    ds_connected_in <= 4'hB;
    tick(2);
    rdc(SU, 32'h2);
    ds_connected_in <= 4'hF;
    // re-enable once SE0 and J are done
    ds_repeat_in <= 4'hF;
    tick(2);
    $display("done port");
  endtask
  task t_wake();
    int w;
    int i;
    hub_suspended_in <= 1'b1;
    wr(SU, 8'h00);
    w = wakes;
    ds_connected_in <= 4'h7;
    tick(4);
    chk("wake", wakes > w, 32'h0);
    ds_connected_in <= 4'hF;
    tick(4);
    wr(SU, 8'h80);
    w = wakes;
    ds_connected_in <= 4'h7;
    tick(4);
    chk("wake", wakes > w, 32'h1);
    chk("hold", fw_hold_out, 32'h1);
    ds_connected_in <= 4'hF;
    tick(HOLD + 8);
    chk("hold", fw_hold_out, 32'h0);
    wr(SU, 8'h00);
    w = wakes;
    i = irqs;
    us_resume_in <= 1'b1;
    tick(1);
    us_resume_in <= 1'b0;
    tick(4);
    chk("wake", wakes > w, 32'h1);
    chk("irq", irqs > i, 32'h1);
    // port remote wakeup with wakeup bit clear
    wr(SU, 8'h01);
    w = wakes;
    k <= 4'h1;
    tick(2);
    k <= 4'h0;
    tick(2);
    chk("wake", wakes > w, 32'h1);
    rdc(RS, 32'h1);
    wr(SU, 8'h00);
    rdc(RS, 32'h0);
    hub_suspended_in <= 1'b0;
    tick(HOLD + 8);
    $display("done wake");
  endtask
  task t_usc();
    logic [3:0] e;
    for (int c = 0; c < 8; c++)
    begin
      e = TBL[c*4 +: 4];
      wr(USC, 8'hC0 | 8'(c));
      chk("pins", {us_dp_oe_out, us_dp_out, us_dm_oe_out, us_dm_out}, e);
      chk("ep", {ep_size_out, ep_mode_out}, 32'h3);
      rdc(USC, {26'h3, e[3] ? e[2] : 1'b1, e[1] & e[0], 1'b0, 3'(c)});
    end
    wr(USC, 8'h00);
    chk("ep", {ep_size_out, ep_mode_out}, 32'h0);
    se_activity_in <= 1'b1;
    tick(1);
    se_activity_in <= 1'b0;
    tick(1);
    rdc(USC, 32'h28);
    wr(USC, 8'h08);
    rdc(USC, 32'h28);
    wr(USC, 8'h00);
    rdc(USC, 32'h20);
    wr(SU, 8'h81);
    eof1_in <= 1'b1;
    bus_reset_in <= 1'b1;
    tick(1);
    eof1_in <= 1'b0;
    bus_reset_in <= 1'b0;
    tick(1);
    rdc(SU, 32'h0);
    $display("done upstream");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_susp();
    t_port();
    t_wake();
    t_usc();
    close_out();
  end
endmodule // tb_top
